/* File: hdl/asc_pkg.sv */
// constants and types of the converter sleep and trigger control
// Operation
// - with the rc clock selected, a requested conversion starts only after one instruction cycle.
// - at the end of a conversion the go flag clears and the result is written to result_high and result_low.
// - a conversion that ends in sleep with conv_irq_mask and peripheral_irq_gate set wakes the device.
// - after that wake-up the core takes the interrupt vector if global_irq_gate is set, else the next instruction.
// - with the converter interrupt disabled, a conversion ending in sleep powers the converter down, converter_on stays one.
// - sleep with a clock other than the rc clock aborts a running conversion and powers down, converter_on stays one.
// - a device reset returns the control registers to reset values, powers down and aborts any conversion.
// - a reset other than power-on leaves both result registers unchanged.
// - with compare_mode_field at the special-event pattern and the converter on, a compare trigger starts a conversion and zeroes the compare timer.
// - with converter_on at zero the trigger is ignored by the converter but still zeroes the compare timer.
// - writing one to the go flag in a write that keeps converter_on one starts a conversion; the flag stays one while busy and clears in hardware when done.
// - conv_clock_sel selects the rc clock whenever its two low bits are both one.
// - justify_select one puts the result right-justified, zero left-justified, across the result pair.
package asc_pkg;
  localparam int ADDR_W = 5;
  localparam int RES_W = 10;
  localparam int IRQ_N = 2;
  localparam int CONV_CYCLES_DEF = 12;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CLKSEL = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RESH = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RESL = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_GATES = 5'h18;
  // ****************************************
  // fields and values
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GATES_RST = 8'h00;
  localparam logic [2:0] CLKSEL_RST = 3'h0;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;
  localparam int CLKSEL_LSB = 4;
  localparam logic [3:0] CMP_SPECIAL = 4'hb;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] RES_PAD = 6'h00;
  typedef struct packed {
    logic justify_select;
    logic vref_sel;
    logic [3:0] chan_sel;
    logic go;
    logic converter_on;
  } asc_ctrl_t;
  typedef struct packed {
    logic [3:0] compare_mode_field;
    logic [1:0] spare;
    logic global_irq_gate;
    logic peripheral_irq_gate;
  } asc_gates_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } asc_result_t;
  typedef enum {ST_IDLE, ST_WAIT_INSTR, ST_CONVERT} asc_state_t;
endpackage : asc_pkg

/* File: hdl/asc_sticky_flags.sv */
// sticky event flags, cleared by writing one
`timescale 1ns/1ns
module asc_sticky_flags #(
  parameter int N = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [N-1:0] set,
  input wire logic clr_wr,
  input wire logic [N-1:0] clr_data,
  output logic [N-1:0] flags
);
  logic [N-1:0] flags_r;
  logic [N-1:0] clr_mask;
  logic [N-1:0] flags_nxt;
  // set wins over a clear in the same cycle
  assign clr_mask = clr_wr ? clr_data : '0;
  assign flags_nxt = (flags_r & ~clr_mask) | set;
  assign flags = flags_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule : asc_sticky_flags

/* File: hdl/asc_adc_ctrl.sv */
// converter control with sleep, wake and compare trigger
`timescale 1ns/1ns
module asc_adc_ctrl #(
  parameter int CONV_CYCLES = asc_pkg::CONV_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_in,
  input wire logic instr_tick,
  input wire logic cmp_trigger,
  input wire logic [asc_pkg::RES_W-1:0] analog_result,
  output logic analog_enable,
  output logic conv_active,
  output logic compare_timer_clr,
  output logic wake_req,
  output logic vector_req,
  output logic resume_next,
  output logic irq
);
  import asc_pkg::*;
  localparam int CNT_W = (CONV_CYCLES > 1) ? $clog2(CONV_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

  // ****************************************
  // bus slave
  // ****************************************
  logic aw_hold_r, w_hold_r, wstrb0_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [7:0] wdata_r, rd_byte;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire, wr_en, wr_map, rd_fire, rd_map;
  logic wr_ctrl, wr_clksel, wr_stat, wr_mask, wr_gates;

  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready = ~w_hold_r;
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_en = wr_fire & wstrb0_r;
  assign wr_ctrl = wr_en & (waddr_r == OFS_CTRL);
  assign wr_clksel = wr_en & (waddr_r == OFS_CLKSEL);
  assign wr_stat = wr_en & (waddr_r == OFS_IRQ_STAT);
  assign wr_mask = wr_en & (waddr_r == OFS_IRQ_MASK);
  assign wr_gates = wr_en & (waddr_r == OFS_GATES);
  assign wr_map = (waddr_r == OFS_CTRL) | (waddr_r == OFS_CLKSEL) | (waddr_r == OFS_RESH)
                | (waddr_r == OFS_RESL) | (waddr_r == OFS_IRQ_STAT) | (waddr_r == OFS_IRQ_MASK)
                | (waddr_r == OFS_GATES);
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign rd_fire = s_axi_arvalid & ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= {24'h000000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  asc_ctrl_t ctrl_r;
  asc_ctrl_t ctrl_nxt;
  asc_ctrl_t ctrl_wr;
  asc_gates_t gates_r;
  logic [2:0] clk_sel_r;
  logic [IRQ_N-1:0] mask_r;
  logic [IRQ_N-1:0] stat;
  asc_result_t res_r;
  asc_result_t res_nxt;
  logic pwr_down_r;
  logic pwr_down_nxt;
  asc_state_t state_r;
  asc_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic wake_r;
  logic vector_r;
  logic resume_r;
  logic timer_clr_r;

  assign rd_map = (s_axi_araddr == OFS_CTRL) | (s_axi_araddr == OFS_CLKSEL) | (s_axi_araddr == OFS_RESH)
                | (s_axi_araddr == OFS_RESL) | (s_axi_araddr == OFS_IRQ_STAT)
                | (s_axi_araddr == OFS_IRQ_MASK) | (s_axi_araddr == OFS_GATES);
  assign rd_byte = (s_axi_araddr == OFS_CTRL) ? ctrl_r :
                   (s_axi_araddr == OFS_CLKSEL) ? {1'b0, clk_sel_r, 4'h0} :
                   (s_axi_araddr == OFS_RESH) ? res_r.high :
                   (s_axi_araddr == OFS_RESL) ? res_r.low :
                   (s_axi_araddr == OFS_IRQ_STAT) ? {6'h00, stat} :
                   (s_axi_araddr == OFS_IRQ_MASK) ? {6'h00, mask_r} :
                   (s_axi_araddr == OFS_GATES) ? gates_r : 8'h00;

  // ****************************************
  // conversion sequencer
  // ****************************************
  logic rc_sel;
  logic busy;
  logic sw_start;
  logic trig_hit;
  logic trig_start;
  logic start_ok;
  logic sleep_abort;
  logic off_abort;
  logic abort;
  logic done_p;
  logic done_sleep;
  logic irq_en;

  assign ctrl_wr = wr_ctrl ? asc_ctrl_t'(wdata_r) : ctrl_r;
  assign rc_sel = (clk_sel_r[1:0] == CLK_RC_LOW);
  assign busy = (state_r != ST_IDLE);
  assign sw_start = wr_ctrl & ctrl_wr.go & ctrl_wr.converter_on;
  // trigger relies on software having acquired the channel
  assign trig_hit = cmp_trigger & (gates_r.compare_mode_field == CMP_SPECIAL);
  assign trig_start = trig_hit & ctrl_r.converter_on;
  assign sleep_abort = sleep_in & ~rc_sel & busy;
  assign off_abort = busy & ~ctrl_wr.converter_on;
  assign abort = sleep_abort | off_abort;
  assign start_ok = ~busy & (sw_start | trig_start) & ~(sleep_in & ~rc_sel);
  assign done_p = (state_r == ST_CONVERT) & (cnt_r == CNT_LAST) & ~abort;
  assign done_sleep = done_p & sleep_in;
  assign irq_en = mask_r[IRQ_DONE] & gates_r.peripheral_irq_gate;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (start_ok) begin
          state_nxt = rc_sel ? ST_WAIT_INSTR : ST_CONVERT;
        end
      end
      ST_WAIT_INSTR: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (instr_tick) begin
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (abort || done_p) begin
          state_nxt = ST_IDLE;
          cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // go follows the sequencer; converter_on is never cleared by hardware
  always_comb begin
    ctrl_nxt = ctrl_wr;
    ctrl_nxt.go = (state_nxt != ST_IDLE);
  end

  // sleep power-down keeps converter_on; lifted when sleep ends
  assign pwr_down_nxt = sleep_in & (pwr_down_r | (~rc_sel) | (done_sleep & ~irq_en));

  // result pair from justify_select
  assign res_nxt.high = ctrl_r.justify_select ? {RES_PAD, analog_result[9:8]} : analog_result[9:2];
  assign res_nxt.low = ctrl_r.justify_select ? analog_result[7:0] : {analog_result[1:0], RES_PAD};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      clk_sel_r <= CLKSEL_RST;
      gates_r <= GATES_RST;
      mask_r <= IRQ_RST;
      state_r <= ST_IDLE;
      cnt_r <= '0;
      pwr_down_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pwr_down_r <= pwr_down_nxt;
      if (wr_clksel) begin
        clk_sel_r <= wdata_r[CLKSEL_LSB+2:CLKSEL_LSB];
      end
      if (wr_gates) begin
        gates_r <= wdata_r;
      end
      if (wr_mask) begin
        mask_r <= wdata_r[IRQ_N-1:0];
      end
    end
  end

  // result survives every reset but power-on
  always_ff @(posedge core_clk) begin
    if (rst && por) begin
      res_r <= '0;
    end else if (done_p && !rst) begin
      res_r <= res_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_r <= 1'b0;
      vector_r <= 1'b0;
      resume_r <= 1'b0;
      timer_clr_r <= 1'b0;
    end else begin
      wake_r <= done_sleep & irq_en;
      vector_r <= done_sleep & irq_en & gates_r.global_irq_gate;
      resume_r <= done_sleep & irq_en & ~gates_r.global_irq_gate;
      timer_clr_r <= trig_hit;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  asc_sticky_flags #(.N(IRQ_N)) asc_sticky_flags_i (
    .core_clk(core_clk),
    .rst(rst),
    .set({sleep_abort, done_p}),
    .clr_wr(wr_stat),
    .clr_data(wdata_r[IRQ_N-1:0]),
    .flags(stat)
  );

  assign irq = |(stat & mask_r);
  assign analog_enable = ctrl_r.converter_on & ~pwr_down_r;
  assign conv_active = busy;
  assign compare_timer_clr = timer_clr_r;
  assign wake_req = wake_r;
  assign vector_req = vector_r;
  assign resume_next = resume_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking

  chk_rc_start_wait: assert property (disable iff (rst)
    (state_r == ST_IDLE && start_ok && rc_sel) |=> (state_r == ST_WAIT_INSTR) && ctrl_r.go)
    else $error("rc start did not wait for an instruction");
  chk_done_clears_go: assert property (disable iff (rst)
    done_p |=> !ctrl_r.go && stat[IRQ_DONE] && !conv_active)
    else $error("go or done flag wrong after completion");
  chk_result_right: assert property (disable iff (rst)
    (done_p && ctrl_r.justify_select) |=> res_r.low == $past(analog_result[7:0])
      && res_r.high == {RES_PAD, $past(analog_result[9:8])})
    else $error("right-justified result wrong");
  chk_wake_sleep: assert property (disable iff (rst)
    (done_sleep && irq_en) |=> wake_req ##1 !wake_req)
    else $error("no wake pulse after sleep conversion");
  chk_wake_vector: assert property (disable iff (rst)
    wake_req |-> (vector_req == $past(gates_r.global_irq_gate)) && (resume_next != vector_req))
    else $error("vector or resume choice wrong");
  chk_sleep_powerdown: assert property (disable iff (rst)
    (done_sleep && !irq_en) |=> !analog_enable && ctrl_r.converter_on)
    else $error("converter not powered down after sleep conversion");
  chk_sleep_abort: assert property (disable iff (rst)
    (sleep_abort && !wr_ctrl) |=> !ctrl_r.go && ctrl_r.converter_on && !analog_enable)
    else $error("sleep abort wrong");
  chk_reset_ctrl: assert property (
    rst |=> ctrl_r == CTRL_RST && !analog_enable && !conv_active)
    else $error("reset left control state");
  chk_result_keep: assert property (
    (rst && !por) |=> $stable(res_r))
    else $error("result changed on warm reset");
  chk_trig_start: assert property (disable iff (rst)
    (trig_start && !busy && !sleep_in) |=> ctrl_r.go && compare_timer_clr)
    else $error("trigger did not start conversion");
  chk_trig_ignored: assert property (disable iff (rst)
    (trig_hit && !ctrl_r.converter_on) |=> !ctrl_r.go && compare_timer_clr)
    else $error("trigger handling wrong with converter off");

  cov_sleep_wake: cover property (disable iff (rst) done_sleep && irq_en);
  cov_trig_conv: cover property (disable iff (rst) trig_start ##[1:40] done_p);
  cov_sleep_abort: cover property (disable iff (rst) sleep_abort);
endmodule : asc_adc_ctrl

/* File: tb/asc_core_model.sv */
// partner model: core instruction ticks and compare trigger
`timescale 1ns/1ns
module asc_core_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick_en,
  input wire logic trig_req,
  output logic instr_tick,
  output logic cmp_trigger
);
  int cnt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 0;
      instr_tick <= 1'b0;
      cmp_trigger <= 1'b0;
    end else begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      instr_tick <= tick_en && cnt == 0;
      cmp_trigger <= trig_req;
    end
  end
endmodule : asc_core_model

/* File: tb/asc_adc_ctrl_tb.sv */
// self-checking bench of the converter sleep and trigger control
`timescale 1ns/1ns
module asc_adc_ctrl_tb;
  import asc_pkg::*;
  localparam int CONV_N = 6;
  logic core_clk, rst, por, sleep_in, tick_en, trig_req, instr_tick, cmp_trigger;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_bresp;
  logic ana_en, busy, tmr_clr, wake, vec, nxt, irq;
  logic [RES_W-1:0] ana_res, last_v;
  logic [33:0] exp_q[$];
  logic [ADDR_W-1:0] ofs [7] = '{OFS_CTRL, OFS_CLKSEL, OFS_RESH, OFS_RESL, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_GATES};
  int n_fail, samples_checked, n_wake, n_vec, n_next, n_clr;
  // ********************
  // clock and instances
  // ********************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  asc_adc_ctrl #(.CONV_CYCLES(CONV_N)) asc_adc_ctrl_i (
    .core_clk(core_clk), .rst(rst), .por(por), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_in(sleep_in),
    .instr_tick(instr_tick), .cmp_trigger(cmp_trigger), .analog_result(ana_res), .analog_enable(ana_en),
    .conv_active(busy), .compare_timer_clr(tmr_clr), .wake_req(wake), .vector_req(vec),
    .resume_next(nxt), .irq(irq));
  asc_core_model asc_core_model_i (.core_clk(core_clk), .rst(rst), .tick_en(tick_en), .trig_req(trig_req),
    .instr_tick(instr_tick), .cmp_trigger(cmp_trigger));
  // ********************
  // tasks
  // ********************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic do_reset(input logic p);
    rst <= 1'b1;
    por <= p;
    cyc(3);
    rst <= 1'b0;
    por <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic aw_hs, w_hs, b_hs;
    int n;
    b_hs = 1'b0;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs && n < 100) begin
      @(negedge core_clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      last_bresp = bresp;
      @(posedge core_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_hs) n_fail++;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] exp);
    logic ar_hs, r_hs;
    int n;
    r_hs = 1'b0;
    n = 0;
    exp_q.push_back(exp);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs && n < 100) begin
      @(negedge core_clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      @(posedge core_clk);
      if (ar_hs) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_hs) n_fail++;
  endtask : rd
  task automatic wait_idle(input logic ei);
    int n;
    n = 0;
    @(negedge core_clk);
    while (busy !== 1'b0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) n_fail++;
    check(irq, ei);
    @(posedge core_clk);
  endtask : wait_idle
  function automatic logic [33:0] res_h(input logic j, input logic [RES_W-1:0] v);
    return j ? {RESP_OKAY, 30'h0, v[9:8]} : {RESP_OKAY, 24'h0, v[9:2]};
  endfunction : res_h
  function automatic logic [33:0] res_l(input logic j, input logic [RES_W-1:0] v);
    return j ? {RESP_OKAY, 24'h0, v[7:0]} : {RESP_OKAY, 24'h0, v[1:0], 6'h0};
  endfunction : res_l
  task automatic conv(input logic [2:0] cs, input logic j);
    last_v = RES_W'($urandom());
    ana_res <= last_v;
    wr(OFS_CLKSEL, {1'b0, cs, 4'h0});
    wr(OFS_IRQ_STAT, 8'h03);
    wr(OFS_CTRL, {j, 5'h0, 2'h3});
    wait_idle(1'b1);
    rd(OFS_CTRL, {RESP_OKAY, 24'h0, j, 7'h1});
    rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h1});
    rd(OFS_RESH, res_h(j, last_v));
    rd(OFS_RESL, res_l(j, last_v));
  endtask : conv
  // ********************
  // monitor and watchdog
  // ********************
  always @(negedge core_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
      check({rresp, rdata}, exp_q.pop_front());
    end
    if (wake === 1'b1) n_wake++;
    if (vec === 1'b1) n_vec++;
    if (nxt === 1'b1) n_next++;
    if (tmr_clr === 1'b1) n_clr++;
  end
  initial begin
    cyc(20000);
    n_fail++;
    print_verdict();
  end
  // ********************
  // tests
  // ********************
  initial begin
    rst = 1'b1;
    por = 1'b1;
    sleep_in = 1'b0;
    tick_en = 1'b1;
    trig_req = 1'b0;
    ana_res = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(32'haf3f));
    cyc(3);
    rst <= 1'b0;
    por <= 1'b0;
    foreach (ofs[k]) rd(ofs[k], {RESP_OKAY, 32'h0});
    rd(5'h1c, {RESP_SLVERR, 32'h0});
    wr(5'h1c, 8'hff);
    check(last_bresp, RESP_SLVERR);
    $display("test reset values done");
    wr(OFS_IRQ_MASK, 8'h01);
    for (int k = 0; k < 8; k++) conv(k[2:0], ^k[2:0]);
    wr(OFS_RESH, 8'hff);
    rd(OFS_RESH, res_h(1'b1, last_v));
    tick_en <= 1'b0;
    wr(OFS_CLKSEL, 8'h70);
    wr(OFS_IRQ_STAT, 8'h03);
    wr(OFS_CTRL, 8'h03);
    cyc(12);
    rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h0});
    tick_en <= 1'b1;
    wait_idle(1'b1);
    wr(OFS_IRQ_MASK, 8'h00);
    @(negedge core_clk);
    check(irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h01);
    @(negedge core_clk);
    check(irq, 1'b1);
    wr(OFS_IRQ_STAT, 8'h01);
    @(negedge core_clk);
    check(irq, 1'b0);
    $display("test conversions done");
    for (int g = 0; g < 3; g++) begin
      wr(OFS_IRQ_MASK, {7'h0, g < 2});
      wr(OFS_GATES, {6'h0, g == 0, 1'b1});
      wr(OFS_IRQ_STAT, 8'h03);
      n_wake = 0;
      n_vec = 0;
      n_next = 0;
      sleep_in <= 1'b1;
      wr(OFS_CTRL, 8'h03);
      wait_idle(g < 2);
      cyc(2);
      @(negedge core_clk);
      check(n_wake, g < 2);
      check(n_vec, g == 0);
      check(n_next, g == 1);
      check(ana_en, g < 2);
      rd(OFS_CTRL, {RESP_OKAY, 32'h1});
      sleep_in <= 1'b0;
    end
    cyc(2);
    @(negedge core_clk);
    check(ana_en, 1'b1);
    $display("test sleep wake done");
    wr(OFS_CLKSEL, 8'h40);
    wr(OFS_IRQ_STAT, 8'h03);
    wr(OFS_CTRL, 8'h03);
    sleep_in <= 1'b1;
    wait_idle(1'b0);
    rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h2});
    rd(OFS_CTRL, {RESP_OKAY, 32'h1});
    @(negedge core_clk);
    check(ana_en, 1'b0);
    @(posedge core_clk);
    sleep_in <= 1'b0;
    wr(OFS_IRQ_STAT, 8'h03);
    wr(OFS_CTRL, 8'h03);
    wr(OFS_CTRL, 8'h00);
    wait_idle(1'b0);
    rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h0});
    rd(OFS_CTRL, {RESP_OKAY, 32'h0});
    $display("test sleep abort done");
    for (int c = 0; c < 3; c++) begin
      wr(OFS_GATES, {c == 2 ? 4'ha : CMP_SPECIAL, 4'h0});
      wr(OFS_CTRL, {7'h0, c != 1});
      n_clr = 0;
      trig_req <= 1'b1;
      cyc(1);
      trig_req <= 1'b0;
      cyc(4);
      @(negedge core_clk);
      check(busy, c == 0);
      check(n_clr, c != 2);
      wait_idle(1'b0);
    end
    $display("test compare trigger done");
    wr(OFS_IRQ_MASK, 8'h01);
    conv(3'h0, 1'b1);
    ana_res <= ~last_v;
    wr(OFS_CTRL, 8'h03);
    do_reset(1'b0);
    @(negedge core_clk);
    check(busy, 1'b0);
    check(ana_en, 1'b0);
    foreach (ofs[k]) if (k < 2 || k > 3) rd(ofs[k], {RESP_OKAY, 32'h0});
    rd(OFS_RESH, res_h(1'b1, last_v));
    rd(OFS_RESL, res_l(1'b1, last_v));
    do_reset(1'b1);
    rd(OFS_RESL, {RESP_OKAY, 32'h0});
    $display("test device reset done");
    print_verdict();
  end
endmodule : asc_adc_ctrl_tb
